//--- design/panel_cfg.svh
// Offsets, field positions, reset values and timing counts for the panel.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CODE 8'h04
`define OFS_STATUS 8'h08
`define OFS_SEARCH 8'h0C
`define OFS_ELEM_IDX 8'h10
`define OFS_ELEM_DATA 8'h14

// ----------------------------------------------------------------------
// Control register fields (write-one pulses plus loop select)
// ----------------------------------------------------------------------
`define CTRL_SEARCH_BIT 0
`define CTRL_RELOCK_BIT 1
`define CTRL_LOOP_LSB 4

// ----------------------------------------------------------------------
// Reset values and code entry
// ----------------------------------------------------------------------
`define CODE_RST 8'h1B
`define CODE_DIGITS 3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 100
`define BUZZ_HALF_MS 250
`define BUZZ_HALF_CYC (`BUZZ_HALF_MS * 1000 * `CLK_MHZ)

`endif

//--- design/panel_pkg.sv
// Types shared by the front-panel supervisor and its element table.
// Assumes nothing beyond a SystemVerilog compiler.
package panel_pkg;

  // ----------------------------------------------------------------------
  // Keypad, one bit per key
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic buzz_stop;
    logic enter;
    logic up;
    logic down;
    logic left;
    logic right;
    logic evac;
    logic silence;
    logic reset;
  } keys_t;

  typedef enum logic [1:0] {LOCKED, CODE_ENTRY, UNLOCKED} lock_state_t;
  typedef enum logic [1:0] {INC_ALARM, INC_ACT, INC_FAULT} inc_t;

  // One discovered loop element
  typedef struct packed {
    logic [1:0] loop;
    logic [3:0] etype;
    logic [7:0] prog;
  } elem_entry_t;

endpackage : panel_pkg

//--- design/elem_table.sv
// Element table: one entry per element found by a loop search.
// Assumes one writer and one reader on the same clock; read data registered.
`timescale 1ns/1ns
module elem_table
  import panel_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic aclk, // System clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write index
  input wire elem_entry_t wdata, // Entry to store
  input wire logic [AW-1:0] raddr, // Read index
  output elem_entry_t rdata_r // Registered read entry
);

  elem_entry_t mem [DEPTH];

  // ----------------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------------
  // No reset on the array; a read of an unwritten entry returns whatever the array holds
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule : elem_table

//--- design/panel_supervisor.sv
// Front-panel supervisor: buzzer, keypad lock, incident display, evacuation,
// silence, event reset and loop element search, with AXI4-Lite registers.
// Assumes keys and incident lines come from pins; the loop transceiver
// driving the element report port runs on aclk.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "panel_cfg.svh"

module panel_supervisor
  import panel_pkg::*;
#(
  parameter int BUZZ_HALF = `BUZZ_HALF_CYC,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  // AXI4-Lite slave
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready_r, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready_r, // Write data ready
  output logic [1:0] bresp_r, // Write response
  output logic bvalid_r, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready_r, // Read address ready
  output logic [31:0] rdata_r, // Read data
  output logic [1:0] rresp_r, // Read response
  output logic rvalid_r, // Read data valid
  input wire logic rready, // Read data ready
  // Front panel
  input wire keys_t keys, // Key pins, high while pressed
  output logic buzzer_r, // Buzzer drive
  output logic evac_led_r, // Evacuation lamp
  output logic silence_led_r, // Silence lamp
  output logic code_prompt_r, // Code prompt on screen
  output logic [1:0] disp_r, // Incident type shown
  // Field side
  input wire logic alarm_in, // Fire alarm present (pin)
  input wire logic act_in, // Relay actuated (pin)
  input wire logic fault_in, // Fault present (pin)
  output logic sirens_r, // All siren outputs
  output logic switches_r, // All switch outputs
  output logic search_req_r, // Search running on loop
  output logic [1:0] search_loop_r, // Loop being searched
  input wire logic elem_valid, // Element report strobe
  input wire logic [3:0] elem_type, // Reported element type
  input wire logic [7:0] elem_prog, // Reported programming number
  input wire logic search_done // End of search strobe
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  keys_t keys_m_r, keys_s_r, keys_d_r;
  logic [2:0] inc_m_r, inc_s_r, inc_d_r;

  // Two flops before any logic sees a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keys_m_r <= '0;
      keys_s_r <= '0;
      inc_m_r <= 3'h0;
      inc_s_r <= 3'h0;
    end else begin
      keys_m_r <= keys;
      keys_s_r <= keys_m_r;
      inc_m_r <= {fault_in, act_in, alarm_in};
      inc_s_r <= inc_m_r;
    end
  end

  // Delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keys_d_r <= '0;
      inc_d_r <= 3'h0;
    end else begin
      keys_d_r <= keys_s_r;
      inc_d_r <= inc_s_r;
    end
  end

  keys_t press;
  logic [2:0] inc_rise;
  logic other_key;
  logic dir_key;
  logic [1:0] dir_val;
  assign press = keys_s_r & ~keys_d_r;
  assign inc_rise = inc_s_r & ~inc_d_r;
  assign other_key = press.enter | press.up | press.down | press.left |
                     press.right | press.evac | press.silence | press.reset;
  assign dir_key = press.up | press.down | press.left | press.right;
  // Digit value per direction key
  assign dir_val = press.up ? 2'h0 : press.down ? 2'h1 :
                   press.left ? 2'h2 : 2'h3;

  // ----------------------------------------------------------------------
  // Register bus state
  // ----------------------------------------------------------------------
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r;
  logic wr_go;
  logic [7:0] code_r;
  logic [AW-1:0] elem_idx_r;
  logic search_pulse, relock_pulse;
  logic [1:0] loop_sel;
  assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
  assign search_pulse = wr_go && aw_addr_r == `OFS_CTRL && w_strb_r[0] &&
                        w_data_r[`CTRL_SEARCH_BIT];
  assign relock_pulse = wr_go && aw_addr_r == `OFS_CTRL && w_strb_r[0] &&
                        w_data_r[`CTRL_RELOCK_BIT];
  assign loop_sel = w_data_r[`CTRL_LOOP_LSB +: 2];

  // Address and data taken in either order, held until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else begin
      if (awvalid && awready_r) begin
        aw_addr_r <= awaddr;
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        // Unmapped or read-only address answers SLVERR
        bresp_r <= (aw_addr_r == `OFS_CTRL || aw_addr_r == `OFS_CODE ||
                    aw_addr_r == `OFS_ELEM_IDX) ? 2'h0 : 2'h2;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Writable configuration: access code and table read index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_r <= `CODE_RST;
      elem_idx_r <= '0;
    end else if (wr_go && w_strb_r[0]) begin
      if (aw_addr_r == `OFS_CODE) begin
        code_r <= w_data_r[7:0];
      end
      if (aw_addr_r == `OFS_ELEM_IDX) begin
        elem_idx_r <= w_data_r[AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Keypad lock and code entry
  // ----------------------------------------------------------------------
  lock_state_t lock_r;
  logic [7:0] entry_r;
  logic [2:0] digits_r;
  logic [7:0] entry_nxt;
  logic unlocked;
  assign unlocked = lock_r == UNLOCKED;
  assign entry_nxt = {entry_r[5:0], dir_val};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= LOCKED;
      entry_r <= 8'h00;
      digits_r <= 3'h0;
    end else if (relock_pulse) begin
      lock_r <= LOCKED;
    end else begin
      case (lock_r)
        LOCKED: begin
          if (other_key) begin
            lock_r <= CODE_ENTRY;
            entry_r <= 8'h00;
            digits_r <= 3'h0;
          end
        end
        CODE_ENTRY: begin
          if (dir_key) begin
            entry_r <= entry_nxt;
            digits_r <= digits_r + 3'h1;
            if (digits_r + 3'h1 == `CODE_DIGITS) begin
              // Wrong code drops back with nothing performed
              lock_r <= (entry_nxt == code_r) ? UNLOCKED : LOCKED;
            end
          end
        end
        UNLOCKED: lock_r <= UNLOCKED;
        default: lock_r <= LOCKED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Incident latches and event reset
  // ----------------------------------------------------------------------
  logic [2:0] inc_r;
  logic reset_pend_r;
  logic confirm;
  logic [2:0] clr_mask;
  // Function keys other than buzzer stop act only with the keypad unlocked
  assign confirm = unlocked & reset_pend_r & press.enter;
  assign clr_mask = confirm ? (3'h1 << disp_r) : 3'h0;

  // Set wins over clear, so a standing fault reports again at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inc_r <= 3'h0;
    end else begin
      inc_r <= (inc_r & ~clr_mask) | inc_s_r;
    end
  end

  // Reset key arms the clear of the shown event; ENTER confirms it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pend_r <= 1'b0;
    end else if (!unlocked || confirm) begin
      reset_pend_r <= 1'b0;
    end else if (press.reset) begin
      reset_pend_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Incident display selection
  // ----------------------------------------------------------------------
  logic [1:0] disp_nxt;
  always_comb begin
    disp_nxt = disp_r;
    case (disp_r)
      INC_ALARM: disp_nxt = inc_r[INC_ACT] ? INC_ACT :
                            inc_r[INC_FAULT] ? INC_FAULT : INC_ALARM;
      INC_ACT: disp_nxt = inc_r[INC_FAULT] ? INC_FAULT :
                          inc_r[INC_ALARM] ? INC_ALARM : INC_ACT;
      INC_FAULT: disp_nxt = inc_r[INC_ALARM] ? INC_ALARM :
                            inc_r[INC_ACT] ? INC_ACT : INC_FAULT;
      default: disp_nxt = INC_ALARM;
    endcase
  end

  // ENTER steps the view unless it is confirming a reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_r <= INC_ALARM;
    end else if (unlocked && press.enter && !reset_pend_r) begin
      disp_r <= disp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Buzzer
  // ----------------------------------------------------------------------
  logic buzz_on_r;
  logic buzz_phase_r;
  logic [31:0] buzz_cnt_r;

  // New incident rearms even after a stop; stop clears no latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buzz_on_r <= 1'b0;
    end else if (|inc_rise) begin
      buzz_on_r <= 1'b1;
    end else if (press.buzz_stop) begin
      buzz_on_r <= 1'b0;
    end
  end

  // Intermittent pattern, free running so the cadence stays even
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buzz_cnt_r <= 32'h0000_0000;
      buzz_phase_r <= 1'b0;
    end else if (buzz_cnt_r == 32'(BUZZ_HALF - 1)) begin
      buzz_cnt_r <= 32'h0000_0000;
      buzz_phase_r <= ~buzz_phase_r;
    end else begin
      buzz_cnt_r <= buzz_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buzzer_r <= 1'b0;
    end else begin
      buzzer_r <= buzz_on_r & ~buzz_phase_r;
    end
  end

  // ----------------------------------------------------------------------
  // Evacuation and silence
  // ----------------------------------------------------------------------
  logic evac_r;
  logic silence_r;

  // Evacuation holds until an event reset is confirmed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evac_r <= 1'b0;
    end else if (unlocked && press.evac) begin
      evac_r <= 1'b1;
    end else if (confirm) begin
      evac_r <= 1'b0;
    end
  end

  // Silence key toggles; the lamp is the state itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      silence_r <= 1'b0;
    end else if (unlocked && press.silence) begin
      silence_r <= ~silence_r;
    end
  end

  // Sirens follow evacuation or an alarm, but never while silenced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sirens_r <= 1'b0;
      switches_r <= 1'b0;
      evac_led_r <= 1'b0;
      silence_led_r <= 1'b0;
      code_prompt_r <= 1'b0;
    end else begin
      sirens_r <= (evac_r | inc_r[INC_ALARM]) & ~silence_r;
      switches_r <= evac_r;
      evac_led_r <= evac_r;
      silence_led_r <= silence_r;
      code_prompt_r <= lock_r == CODE_ENTRY;
    end
  end

  // ----------------------------------------------------------------------
  // Loop element search
  // ----------------------------------------------------------------------
  logic [AW:0] found_r;
  logic tbl_we;
  elem_entry_t tbl_wdata, tbl_rdata;
  // Full table drops further reports rather than wrapping
  assign tbl_we = search_req_r & elem_valid & ~found_r[AW];
  assign tbl_wdata = '{loop: search_loop_r, etype: elem_type,
                       prog: elem_prog};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      search_req_r <= 1'b0;
      search_loop_r <= 2'h0;
      found_r <= '0;
    end else if (search_pulse && !search_req_r) begin
      search_req_r <= 1'b1;
      search_loop_r <= loop_sel;
      found_r <= '0;
    end else if (search_req_r) begin
      if (tbl_we) begin
        found_r <= found_r + 1'b1;
      end
      if (search_done) begin
        search_req_r <= 1'b0;
      end
    end
  end

  // Each entry keeps its element's own number and the searched loop
  elem_table #(.DEPTH(DEPTH), .AW(AW)) u_table (
    .aclk(aclk),
    .we(tbl_we),
    .waddr(found_r[AW-1:0]),
    .wdata(tbl_wdata),
    .raddr(elem_idx_r),
    .rdata_r(tbl_rdata)
  );

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (araddr)
      `OFS_CTRL: rd_val = {26'h0, search_loop_r, 4'h0};
      `OFS_CODE: rd_val = {24'h0, code_r};
      `OFS_STATUS: rd_val = {20'h0, reset_pend_r, silence_r, evac_r,
                             buzz_on_r, disp_r, inc_r, 1'b0, lock_r};
      `OFS_SEARCH: rd_val = {{(24 - AW - 1){1'b0}}, found_r, 7'h0,
                             search_req_r};
      `OFS_ELEM_IDX: rd_val = {{(32 - AW){1'b0}}, elem_idx_r};
      `OFS_ELEM_DATA: rd_val = {18'h0, tbl_rdata};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

endmodule : panel_supervisor

//--- verification/loop_elems.sv
// Behavioural model of the field elements on one loop.
// Assumes the search request is a level on aclk; reports follow it.
`timescale 1ns/1ns
module loop_elems #(
  parameter int N = 3
) (
  input wire logic aclk, // Clock
  input wire logic req, // Search running
  output logic vld = 1'b0, // Report strobe
  output logic [3:0] etype = 4'h5, // Element type
  output logic [7:0] prog = 8'h3C, // Factory number
  output logic done = 1'b0 // End of search
);
  int c = 0;
  // Odd steps report one element; released lines flip every cycle
  always @(posedge aclk) begin
    c <= req ? ((c < 2 * N + 1) ? c + 1 : c) : 0;
    vld <= req && c[0] && c < 2 * N;
    done <= req && c == 2 * N;
    etype <= (req && c[0]) ? 4'(c / 2 + 1) : ~etype;
    prog <= (req && c[0]) ? 8'hA0 + 8'(c / 2) : ~prog;
  end
endmodule : loop_elems

//--- verification/panel_monitor.sv
// Checker for the panel supervisor, watching its ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module panel_monitor
  import panel_pkg::*;
#(
  parameter int BUZZ_HALF = 4
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire keys_t keys, // Key pins
  input wire logic buzzer_r, // Buzzer
  input wire logic evac_led_r, // Evac lamp
  input wire logic silence_led_r, // Silence lamp
  input wire logic code_prompt_r, // Code prompt
  input wire logic [1:0] disp_r, // Shown type
  input wire logic sirens_r, // Sirens
  input wire logic switches_r, // Switches
  input wire logic search_req_r, // Search running
  input wire logic search_done, // Search end
  input wire logic bvalid_r, // Write response
  input wire logic bready, // Write response ready
  input wire logic rvalid_r, // Read response
  input wire logic rready // Read response ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  int hi_n;
  // ------
  // Helpers
  // ------
  // Burst length; a stuck buzzer is the hazard
  always_ff @(posedge aclk) begin
    if (!aresetn || !buzzer_r) hi_n <= 0;
    else hi_n <= hi_n + 1;
  end
  sequence stop_held;
    keys.buzz_stop [*7];
  endsequence
  sequence evac_on;
    (evac_led_r && !silence_led_r) [*2];
  endsequence
  // ------
  // Properties
  // ------
  buzz_burst_a: assert property (hi_n <= BUZZ_HALF)
    else $error("buzzer burst too long");
  stop_quiet_a: assert property (stop_held |=> !buzzer_r)
    else $error("buzzer kept sounding");
  evac_drive_a: assert property (evac_on |-> sirens_r && switches_r)
    else $error("evacuation outputs idle");
  silence_hold_a: assert property (silence_led_r [*2] |-> !sirens_r)
    else $error("siren on while silenced");
  locked_evac_a: assert property (
    $rose(evac_led_r) |-> !$past(code_prompt_r))
    else $error("evacuation during code entry");
  locked_silence_a: assert property (
    $rose(silence_led_r) |-> !$past(code_prompt_r))
    else $error("silence during code entry");
  search_end_a: assert property (
    search_done |-> ##[1:2] !search_req_r)
    else $error("search did not end");
  disp_range_a: assert property (disp_r != 2'h3)
    else $error("bad display type");
  bresp_hold_a: assert property (bvalid_r && !bready |=> bvalid_r)
    else $error("write response dropped");
  rresp_hold_a: assert property (rvalid_r && !rready |=> rvalid_r)
    else $error("read response dropped");
endmodule : panel_monitor

//--- verification/tb_panel_supervisor.sv
// Self-checking bench for the panel supervisor over AXI4-Lite and pins.
// Assumes the loop model answers searches; wstrb is tied high.
`timescale 1ns/1ns
`include "panel_cfg.svh"
bind panel_supervisor panel_monitor #(.BUZZ_HALF(BUZZ_HALF)) mon_inst (
  .aclk(aclk), .aresetn(aresetn), .keys(keys), .buzzer_r(buzzer_r),
  .evac_led_r(evac_led_r), .silence_led_r(silence_led_r),
  .code_prompt_r(code_prompt_r), .disp_r(disp_r), .sirens_r(sirens_r),
  .switches_r(switches_r), .search_req_r(search_req_r),
  .search_done(search_done), .bvalid_r(bvalid_r), .bready(bready),
  .rvalid_r(rvalid_r), .rready(rready));
module tb_panel_supervisor
  import panel_pkg::*;
;
  localparam int NEL = 3;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, buzzer_r;
  logic evac_led_r, silence_led_r, code_prompt_r, sirens_r, switches_r;
  logic alarm_in, act_in, fault_in, search_req_r, ev, sd;
  logic [7:0] awaddr, araddr, ep;
  logic [31:0] wdata, rdata_r;
  logic [1:0] bresp_r, rresp_r, disp_r, search_loop_r;
  logic [3:0] et;
  keys_t keys;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  panel_supervisor #(.BUZZ_HALF(4)) panel_supervisor_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready_r(awready_r), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready_r(wready_r), .bresp_r(bresp_r), .bvalid_r(bvalid_r),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready_r(arready_r), .rdata_r(rdata_r), .rresp_r(rresp_r),
    .rvalid_r(rvalid_r), .rready(rready), .keys(keys), .buzzer_r(buzzer_r),
    .evac_led_r(evac_led_r), .silence_led_r(silence_led_r),
    .code_prompt_r(code_prompt_r), .disp_r(disp_r), .alarm_in(alarm_in),
    .act_in(act_in), .fault_in(fault_in), .sirens_r(sirens_r),
    .switches_r(switches_r), .search_req_r(search_req_r),
    .search_loop_r(search_loop_r), .elem_valid(ev), .elem_type(et),
    .elem_prog(ep), .search_done(sd));
  loop_elems #(.N(NEL)) loop_elems_inst (
    .aclk(aclk), .req(search_req_r), .vld(ev), .etype(et), .prog(ep),
    .done(sd));
  // ------
  // Clock and hang guard
  // ------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ------
  // Tasks
  // ------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    // Loop test runs after the edge, so it sees the raised strobes
    do begin
      @(posedge aclk);
      if (awready_r) awvalid <= 1'b0;
      if (wready_r) wvalid <= 1'b0;
      if (bvalid_r) begin
        bready <= 1'b0;
        r = bresp_r;
      end
    end while (awvalid || wvalid || bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready_r) arvalid <= 1'b0;
      if (rvalid_r) begin
        rready <= 1'b0;
        d = rdata_r;
        r = rresp_r;
      end
    end while (arvalid || rready);
  endtask : rd
  function automatic keys_t kb(input int b);
    return keys_t'(9'h1 << b);
  endfunction : kb
  function automatic logic [31:0] elem_exp(input int i, input logic [1:0] l);
    return {18'h0, l, 4'(i + 1), 8'hA0 + 8'(i)};
  endfunction : elem_exp
  // Held past the two-flop sync so the press is surely seen
  task automatic press(input keys_t k);
    @(posedge aclk);
    keys <= k;
    repeat (8) @(posedge aclk);
    keys <= '0;
    repeat (6) @(posedge aclk);
  endtask : press
  task automatic code(input logic [7:0] c);
    for (int i = 3; i >= 0; i--) press(kb(6 - c[2*i+:2]));
  endtask : code
  task automatic watch(input int n, output bit hi);
    hi = 0;
    repeat (n) begin
      @(posedge aclk);
      if (buzzer_r === 1'b1) hi = 1;
    end
  endtask : watch
  task automatic sel_reset(input logic [1:0] t);
    if (disp_r !== t) press(kb(7));
    press(kb(0));
  endtask : sel_reset
  // ------
  // Main sequence
  // ------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] bad;
    logic [1:0] lp;
    logic [1:0] x;
    bit hi;
    aresetn <= 1'b0;
    keys <= '0;
    {alarm_in, act_in, fault_in, awvalid, wvalid, bready} <= '0;
    {arvalid, rready} <= '0;
    {awaddr, araddr, wdata} <= '0;
    d = $urandom(18673);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({awready_r, wready_r, arready_r, buzzer_r, sirens_r}, 5'h1C);
    rd(`OFS_STATUS, d, r);
    chk(d[1:0], LOCKED);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    wr(`OFS_STATUS, 32'h0, r);
    chk(r, 2'h2);
    alarm_in <= 1'b1;
    watch(40, hi);
    chk(hi, 1);
    press(kb(8));
    watch(40, hi);
    chk(hi, 0);
    rd(`OFS_STATUS, d, r);
    chk(d[3], 1);
    fault_in <= 1'b1;
    watch(40, hi);
    chk(hi, 1);
    press(kb(2));
    chk({code_prompt_r, evac_led_r}, 2'h2);
    bad = 8'($urandom);
    if (bad == `CODE_RST) bad = ~bad;
    code(bad);
    rd(`OFS_STATUS, d, r);
    chk({code_prompt_r, d[1:0]}, {1'b0, LOCKED});
    press(kb(1));
    code(`CODE_RST);
    rd(`OFS_STATUS, d, r);
    chk({silence_led_r, d[1:0]}, {1'b0, UNLOCKED});
    x = disp_r;
    press(kb(7));
    chk(disp_r, (x == 2'h0) ? 2'h2 : 2'h0);
    press(kb(2));
    chk({evac_led_r, switches_r, sirens_r}, 3'h7);
    press(kb(1));
    chk({silence_led_r, sirens_r}, 2'h2);
    alarm_in <= 1'b0;
    sel_reset(2'h0);
    rd(`OFS_STATUS, d, r);
    chk(d[3], 1);
    press(kb(7));
    rd(`OFS_STATUS, d, r);
    chk(d[5:3], 3'h4);
    sel_reset(2'h2);
    press(kb(7));
    rd(`OFS_STATUS, d, r);
    chk(d[5], 1);
    fault_in <= 1'b0;
    sel_reset(2'h2);
    press(kb(7));
    rd(`OFS_STATUS, d, r);
    chk(d[5:3], 3'h0);
    press(kb(8));
    act_in <= 1'b1;
    watch(40, hi);
    chk(hi, 1);
    rd(`OFS_STATUS, d, r);
    chk(d[5:3], 3'h2);
    lp = 2'($urandom);
    wr(`OFS_CTRL, {26'h0, lp, 4'h1}, r);
    chk(search_loop_r, lp);
    repeat (200) if (search_req_r === 1'b1) @(posedge aclk);
    rd(`OFS_SEARCH, d, r);
    chk({d[14:8], d[0]}, {7'(NEL), 1'b0});
    for (int i = 0; i < NEL; i++) begin
      wr(`OFS_ELEM_IDX, i, r);
      rd(`OFS_ELEM_DATA, d, r);
      chk(d, elem_exp(i, lp));
    end
    wr(`OFS_CTRL, 32'h2, r);
    rd(`OFS_STATUS, d, r);
    chk(d[1:0], LOCKED);
    wr(`OFS_CODE, {24'h0, bad}, r);
    chk(r, 2'h0);
    rd(`OFS_CODE, d, r);
    chk(d, {24'h0, bad});
    wrap_up();
  end
endmodule : tb_panel_supervisor
